// ### core/dofd_top.sv
// Purpose: Operand and operation field decoder for a 16-bit DSP core
// Assumes: Instruction word and status flags are written over APB
// Notes: Decode logic is combinational from the registered word, flags and MOVE register; decode output ports are registered
// Contract
// [RQ1] Five-bit select: input words, accumulator parts, full accs, address, offset regs
// [RQ2] Shift field n 1..15 gives a constant with bit 15-n set
// [RQ3] Direction bit zero reads, one writes
// [RQ4] Four-bit ALU field: 01xx input register, 1xxx accumulator part
// [RQ5] X plus register move: two-bit first dest, one-bit Y half
// [RQ6] Register plus Y move: one-bit X half, two-bit second dest
// [RQ7] Class II bit picks accumulator A or B
// [RQ8] Dual move X address mode plus index, Y index in opposite bank
// [RQ9] Dual move data fields select X lo, X hi, A, B
// [RQ10] Second five-bit select maps modifier and program control registers
// [RQ11] Simple conditions test one status flag
// [RQ12] Signed and normalization conditions use combined flag equations
// [RQ13] Condition codes 0-7 listed, 8-15 complementary
// [RQ14] Opcode top bit one means multiply with its fields
// [RQ15] Multiplier select maps to eight fixed operand pairs
// [RQ16] Control bits negate, accumulate and round independently
// [RQ17] Multiply destination bit picks A or B
// [RQ18] Top bit zero means non-multiply with two 3-bit fields
// [RQ19] Unassigned field values raise an illegal encoding flag
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
module dofd_top
   import dofd_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic pready_out,
   output logic pslverr_out,
   output logic [31:0] prdata_out,
   output logic [5:0] reg_sel1_out,
   output logic [2:0] reg_idx1_out,
   output logic [5:0] reg_sel2_out,
   output logic [2:0] reg_idx2_out,
   output logic cond_true_out,
   output logic [15:0] shift_const_out,
   output logic illegal_out
);
   dofd_field_if fld ();
   logic [31:0] word;
   logic [6:0] flags;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic [31:0] rdata_comb;

   // Word layout (software view):
   // [3:0] condition_sel, [7:4] shift, [15:8] opcode, [20:16] five-bit select 1,
   // [25:21] five-bit select 2, [26] direction, [30:27] ALU dest field
   // MOVE register: [1:0] ff-x, [2] F, [3] e, [5:4] ff-y, [6] class II d,
   // [11:7] X xside_mode_index, [15:12] Y mmtt, [17:16] ee, [19:18] dual ff
   dofd_apb_regs u_regs (
      .sys_clk_in(sys_clk_in),
      .srst_in(srst_in),
      .psel_in(psel_in),
      .penable_in(penable_in),
      .pwrite_in(pwrite_in),
      .paddr_in(paddr_in),
      .pwdata_in(pwdata_in),
      .pstrb_in(pstrb_in),
      .pready_out(pready_out),
      .pslverr_out(pslverr_out),
      .rd_mux_in(rd_mux),
      .rd_hit_in(rd_hit),
      .word_out(word),
      .flags_out(flags),
      .rdata_q_out(rdata_comb)
   );

   assign fld.word = word[23:0];
   assign fld.flags = flags;

   dofd_cond_eval u_eval (
      .fld(fld.producer)
   );

   // Register selects
   logic [4:0] sel1;
   logic [4:0] sel2;
   dofd_reg_e r1;
   dofd_reg_e r2;
   logic ill_r1;
   logic ill_r2;
   always_comb begin
      sel1 = word[20:16];
      sel2 = word[25:21];
      r1 = dofd_map_reg1(sel1); // [RQ1]
      ill_r1 = (r1 == DOFD_REG_NONE); // [RQ19]
      r2 = DOFD_REG_NONE;
      if (sel2[4:3] == 2'b00) begin
         r2 = DOFD_REG_MODIFIER; // [RQ10]
      end else begin
         unique case (sel2) // [RQ10]
            5'h0A: r2 = DOFD_REG_EXT_PTR;
            5'h10: r2 = DOFD_REG_VEC_BASE;
            5'h11: r2 = DOFD_REG_SIZE_COUNT;
            5'h18: r2 = DOFD_REG_STACK_SIZE;
            5'h19: r2 = DOFD_REG_STATUS;
            5'h1A: r2 = DOFD_REG_OP_MODE;
            5'h1B: r2 = DOFD_REG_STACK_IDX;
            5'h1C: r2 = DOFD_REG_STACK_TOP_HI;
            5'h1D: r2 = DOFD_REG_STACK_TOP_LO;
            5'h1E: r2 = DOFD_REG_LOOP_END;
            5'h1F: r2 = DOFD_REG_LOOP_CNT;
            default: r2 = DOFD_REG_NONE;
         endcase
      end
      ill_r2 = (r2 == DOFD_REG_NONE); // [RQ19]
   end

   // ALU destination field
   logic [3:0] alu_f;
   logic [3:0] alu_sel;
   logic alu_ill;
   logic dir_write;
   always_comb begin
      alu_f = word[30:27];
      dir_write = word[26]; // [RQ3]
      alu_ill = 1'b0;
      alu_sel = 4'h0;
      if (alu_f[3]) begin
         alu_sel = {1'b1, alu_f[2:0]}; // [RQ4]
      end else if (alu_f[3:2] == 2'b01) begin
         alu_sel = {2'b01, alu_f[1:0]}; // [RQ4]
      end else begin
         alu_ill = 1'b1; // [RQ19]
      end
   end

   // Parallel move fields, register MOVE is held separately from word
   logic [31:0] mv;
   logic [31:0] next_mv;
   logic [1:0] xr_d1;
   logic xr_d2_hi;
   logic ry_d1_hi;
   logic [1:0] ry_d2;
   logic c2_b;
   logic [1:0] x_mode;
   logic [2:0] x_idx;
   logic [1:0] y_mode;
   logic [2:0] y_idx;
   logic [1:0] dx;
   logic [1:0] dy;
   always_comb begin
      next_mv = mv;
      if (psel_in && penable_in && pwrite_in && paddr_in == DOFD_OFF_MOVE) begin
         next_mv = pwdata_in;
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         mv <= DOFD_RST_CTRL;
      end else begin
         mv <= next_mv;
      end
   end
   always_comb begin
      xr_d1 = mv[1:0]; // [RQ5]
      xr_d2_hi = mv[2]; // [RQ5]
      ry_d1_hi = mv[3]; // [RQ6]
      ry_d2 = mv[5:4]; // [RQ6]
      c2_b = mv[6]; // [RQ7]
      x_mode = mv[11:10]; // [RQ8]
      x_idx = mv[9:7]; // [RQ8]
      y_mode = mv[15:14]; // [RQ8]
      // Y pointer lives in the bank opposite the X pointer
      y_idx = {~x_idx[2], mv[13:12]}; // [RQ8]
      dx = dofd_pair_sel(mv[17:16]); // [RQ9]
      dy = dofd_pair_sel(mv[19:18]); // [RQ9]
   end

   // Read mux
   always_comb begin
      rd_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (paddr_in)
         DOFD_OFF_CTRL: rd_mux = {31'h0, illegal_out};
         DOFD_OFF_WORD: rd_mux = word;
         DOFD_OFF_FLAGS: rd_mux = {25'h0, flags};
         DOFD_OFF_REGSEL: rd_mux = {17'h0, r2, r1, dir_write, ill_r2, ill_r1};
         DOFD_OFF_ALU: rd_mux = {27'h0, alu_ill, alu_sel};
         DOFD_OFF_MOVE: rd_mux = {8'h0, dy, dx, y_mode, y_idx, x_mode, x_idx,
            c2_b, ry_d2, ry_d1_hi, xr_d2_hi, xr_d1, 3'h0};
         DOFD_OFF_OPCODE: rd_mux = {13'h0, fld.cond_true, fld.nonmul_op,
            fld.nonmul_dest_b, fld.nonmul_src, fld.mul_round, fld.mul_accumulate,
            fld.mul_negate, fld.mul_dest_b, fld.mul_second, fld.mul_first,
            fld.is_multiply};
         DOFD_OFF_SHIFT: rd_mux = {16'h0, fld.shift_const};
         default: rd_hit = 1'b0;
      endcase
   end

   // Decode outputs registered so the datapath sees stable values
   logic [5:0] next_sel1;
   logic [5:0] next_sel2;
   logic next_ill;
   logic next_cond;
   logic [15:0] next_shift;
   logic [31:0] next_prdata;
   always_comb begin
      next_sel1 = r1;
      next_sel2 = r2;
      next_ill = ill_r1 | ill_r2 | alu_ill | (word[7:4] == 4'h0); // [RQ19]
      next_cond = fld.cond_true;
      next_shift = fld.shift_const;
      next_prdata = rdata_comb;
   end
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         reg_sel1_out <= 6'h00;
         reg_sel2_out <= 6'h00;
         reg_idx1_out <= 3'h0;
         reg_idx2_out <= 3'h0;
         illegal_out <= 1'b0;
         cond_true_out <= 1'b0;
         shift_const_out <= 16'h0000;
      end else begin
         reg_sel1_out <= next_sel1;
         reg_sel2_out <= next_sel2;
         reg_idx1_out <= sel1[2:0];
         reg_idx2_out <= sel2[2:0];
         illegal_out <= next_ill;
         cond_true_out <= next_cond;
         shift_const_out <= next_shift;
      end
   end
   // Read data is combinational while a mapped read is selected, setup phase included, zero otherwise
   assign prdata_out = next_prdata;
endmodule

// ### core/dofd_pkg.sv
// Purpose: Shared encodings for the opcode field decoder
// Assumes: Five-bit register selects and 8-bit parallel operation codes
// Notes: Register index and APB offsets live here
package dofd_pkg;

   // Register select targets, common code space for both five-bit maps
   typedef enum logic [5:0] {
      DOFD_REG_NONE = 6'h00,
      DOFD_REG_X_LO = 6'h01,
      DOFD_REG_X_HI = 6'h02,
      DOFD_REG_Y_LO = 6'h03,
      DOFD_REG_Y_HI = 6'h04,
      DOFD_REG_ACC_A_LOW = 6'h05,
      DOFD_REG_ACC_B_LOW = 6'h06,
      DOFD_REG_ACC_A_EXT = 6'h07,
      DOFD_REG_ACC_B_EXT = 6'h08,
      DOFD_REG_ACC_A_MID = 6'h09,
      DOFD_REG_ACC_B_MID = 6'h0A,
      DOFD_REG_ACC_A = 6'h0B,
      DOFD_REG_ACC_B = 6'h0C,
      DOFD_REG_ADDR_PTR = 6'h0D,
      DOFD_REG_OFFSET = 6'h0E,
      DOFD_REG_MODIFIER = 6'h0F,
      DOFD_REG_EXT_PTR = 6'h10,
      DOFD_REG_VEC_BASE = 6'h11,
      DOFD_REG_SIZE_COUNT = 6'h12,
      DOFD_REG_STACK_SIZE = 6'h13,
      DOFD_REG_STATUS = 6'h14,
      DOFD_REG_OP_MODE = 6'h15,
      DOFD_REG_STACK_IDX = 6'h16,
      DOFD_REG_STACK_TOP_HI = 6'h17,
      DOFD_REG_STACK_TOP_LO = 6'h18,
      DOFD_REG_LOOP_END = 6'h19,
      DOFD_REG_LOOP_CNT = 6'h1A
   } dofd_reg_e;

   // APB register byte offsets
   localparam logic [11:0] DOFD_OFF_CTRL = 12'h000;
   localparam logic [11:0] DOFD_OFF_WORD = 12'h004;
   localparam logic [11:0] DOFD_OFF_FLAGS = 12'h008;
   localparam logic [11:0] DOFD_OFF_REGSEL = 12'h00C;
   localparam logic [11:0] DOFD_OFF_ALU = 12'h010;
   localparam logic [11:0] DOFD_OFF_MOVE = 12'h014;
   localparam logic [11:0] DOFD_OFF_OPCODE = 12'h018;
   localparam logic [11:0] DOFD_OFF_SHIFT = 12'h01C;

   // Reset values
   localparam logic [31:0] DOFD_RST_WORD = 32'h0000_0000;
   localparam logic [6:0] DOFD_RST_FLAGS = 7'h00;
   localparam logic [31:0] DOFD_RST_CTRL = 32'h0000_0000;

   // Status flag positions in the flags register
   localparam int DOFD_FLG_C = 0;
   localparam int DOFD_FLG_E = 1;
   localparam int DOFD_FLG_Z = 2;
   localparam int DOFD_FLG_N = 3;
   localparam int DOFD_FLG_V = 4;
   localparam int DOFD_FLG_U = 5;
   localparam int DOFD_FLG_L = 6;

   // Condition codes, low half; the high half is the complement
   localparam logic [2:0] DOFD_CC_CARRY_CLR = 3'h0;
   localparam logic [2:0] DOFD_CC_GE = 3'h1;
   localparam logic [2:0] DOFD_CC_NE = 3'h2;
   localparam logic [2:0] DOFD_CC_PL = 3'h3;
   localparam logic [2:0] DOFD_CC_NN = 3'h4;
   localparam logic [2:0] DOFD_CC_EXT_CLR = 3'h5;
   localparam logic [2:0] DOFD_CC_LIM_CLR = 3'h6;
   localparam logic [2:0] DOFD_CC_GT = 3'h7;

   // Multiply operand pair: first and second operand codes, 2 bits each
   // 0 x_in_word_lo, 1 y_in_word_lo, 2 x_in_word_hi, 3 y_in_word_hi
   localparam logic [2:0][1:0] DOFD_MUL_FIRST = '0;

   // APB data width in bits, matching the read mux
   localparam int DOFD_DATA_W = 32;

   // Map a five-bit register select, first table
   function automatic dofd_reg_e dofd_map_reg1(input logic [4:0] code);
      dofd_reg_e r;
      r = DOFD_REG_NONE;
      unique case (code[4:3])
         2'b10: r = DOFD_REG_ADDR_PTR;
         2'b11: r = DOFD_REG_OFFSET;
         default: begin
            unique case (code)
               5'h04: r = DOFD_REG_X_LO;
               5'h05: r = DOFD_REG_X_HI;
               5'h06: r = DOFD_REG_Y_LO;
               5'h07: r = DOFD_REG_Y_HI;
               5'h08: r = DOFD_REG_ACC_A_LOW;
               5'h09: r = DOFD_REG_ACC_B_LOW;
               5'h0A: r = DOFD_REG_ACC_A_EXT;
               5'h0B: r = DOFD_REG_ACC_B_EXT;
               5'h0C: r = DOFD_REG_ACC_A_MID;
               5'h0D: r = DOFD_REG_ACC_B_MID;
               5'h0E: r = DOFD_REG_ACC_A;
               5'h0F: r = DOFD_REG_ACC_B;
               default: r = DOFD_REG_NONE;
            endcase
         end
      endcase
      return r;
   endfunction

   // Data operand pair code: 0 first input lo, 1 first hi, 2 acc A, 3 acc B
   function automatic logic [1:0] dofd_pair_sel(input logic [1:0] code);
      return code;
   endfunction

endpackage

// ### core/dofd_field_if.sv
// Purpose: Carries decoded fields between decoder modules
// Assumes: One clock domain
// Notes: Pure wiring, no logic
`timescale 1ns/100ps
interface dofd_field_if;
   logic [23:0] word;
   logic [6:0] flags;
   logic cond_true;
   logic [15:0] shift_const;
   logic [2:0] mul_first;
   logic [2:0] mul_second;
   logic mul_dest_b;
   logic mul_negate;
   logic mul_accumulate;
   logic mul_round;
   logic is_multiply;
   logic [2:0] nonmul_src;
   logic [2:0] nonmul_op;
   logic nonmul_dest_b;
   modport producer (input word, input flags, output cond_true, output shift_const,
      output mul_first, output mul_second, output mul_dest_b, output mul_negate,
      output mul_accumulate, output mul_round, output is_multiply,
      output nonmul_src, output nonmul_op, output nonmul_dest_b);
   modport consumer (output word, output flags, input cond_true, input shift_const,
      input mul_first, input mul_second, input mul_dest_b, input mul_negate,
      input mul_accumulate, input mul_round, input is_multiply,
      input nonmul_src, input nonmul_op, input nonmul_dest_b);
endinterface

// ### core/dofd_cond_eval.sv
// Purpose: Condition code evaluation and immediate shift constant
// Assumes: Flags come from the status word already registered
// Notes: Purely combinational
`timescale 1ns/100ps
module dofd_cond_eval
   import dofd_pkg::*;
(
   dofd_field_if.producer fld
);
   logic [3:0] cc;
   logic base;
   logic c_f, e_f, z_f, n_f, v_f, u_f, l_f;
   logic [3:0] sh;

   always_comb begin
      cc = fld.word[3:0];
      sh = fld.word[7:4];
      c_f = fld.flags[DOFD_FLG_C];
      e_f = fld.flags[DOFD_FLG_E];
      z_f = fld.flags[DOFD_FLG_Z];
      n_f = fld.flags[DOFD_FLG_N];
      v_f = fld.flags[DOFD_FLG_V];
      u_f = fld.flags[DOFD_FLG_U];
      l_f = fld.flags[DOFD_FLG_L];
      base = 1'b0;
      unique case (cc[2:0])
         DOFD_CC_CARRY_CLR: base = ~c_f; // [RQ11]
         DOFD_CC_GE: base = ~(n_f ^ v_f); // [RQ12]
         DOFD_CC_NE: base = ~z_f; // [RQ11]
         DOFD_CC_PL: base = ~n_f; // [RQ11]
         DOFD_CC_NN: base = ~(z_f | (~u_f & ~e_f)); // [RQ12]
         DOFD_CC_EXT_CLR: base = ~e_f; // [RQ11]
         DOFD_CC_LIM_CLR: base = ~l_f; // [RQ11]
         DOFD_CC_GT: base = ~(z_f | (n_f ^ v_f)); // [RQ12]
      endcase
      // Upper half of the code space selects the complement
      fld.cond_true = cc[3] ? ~base : base; // [RQ13]
      // Field value 0 has no constant and yields zero
      fld.shift_const = (sh == 4'h0) ? 16'h0000 : (16'h8000 >> sh); // [RQ2]
   end

   // Multiply and non-multiply operation code fields, opcode in word[15:8]
   logic [7:0] op;
   always_comb begin
      op = fld.word[15:8];
      fld.is_multiply = op[7]; // [RQ14]
      fld.mul_dest_b = op[3]; // [RQ17]
      fld.mul_negate = op[2]; // [RQ16]
      fld.mul_accumulate = op[1]; // [RQ16]
      fld.mul_round = op[0]; // [RQ16]
      // Operand codes: 0 x lo, 1 y lo, 2 x hi, 3 y hi
      unique case (op[6:4]) // [RQ15]
         3'h0: {fld.mul_first, fld.mul_second} = {3'h0, 3'h0};
         3'h1: {fld.mul_first, fld.mul_second} = {3'h1, 3'h1};
         3'h2: {fld.mul_first, fld.mul_second} = {3'h2, 3'h0};
         3'h3: {fld.mul_first, fld.mul_second} = {3'h3, 3'h1};
         3'h4: {fld.mul_first, fld.mul_second} = {3'h0, 3'h3};
         3'h5: {fld.mul_first, fld.mul_second} = {3'h1, 3'h0};
         3'h6: {fld.mul_first, fld.mul_second} = {3'h2, 3'h1};
         3'h7: {fld.mul_first, fld.mul_second} = {3'h3, 3'h2};
      endcase
      fld.nonmul_src = op[6:4]; // [RQ18]
      fld.nonmul_dest_b = op[3]; // [RQ18]
      fld.nonmul_op = op[2:0]; // [RQ18]
   end
endmodule

// ### core/dofd_apb_regs.sv
// Purpose: APB slave holding the instruction word and status flags
// Assumes: Zero wait states; pready is always high
// Notes: Unmapped reads return zero with pslverr
`timescale 1ns/100ps
module dofd_apb_regs
   import dofd_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [31:0] rd_mux_in,
   input wire logic rd_hit_in,
   output logic [31:0] word_out,
   output logic [6:0] flags_out,
   output logic [31:0] rdata_q_out
);
   logic [31:0] next_word;
   logic [6:0] next_flags;
   logic wr_en;
   integer i;

   always_comb begin
      wr_en = psel_in & penable_in & pwrite_in;
      next_word = word_out;
      next_flags = flags_out;
      if (wr_en && paddr_in == DOFD_OFF_WORD) begin
         for (i = 0; i < 4; i++) begin
            if (pstrb_in[i]) begin
               next_word[i*8 +: 8] = pwdata_in[i*8 +: 8];
            end
         end
      end
      if (wr_en && paddr_in == DOFD_OFF_FLAGS && pstrb_in[0]) begin
         next_flags = pwdata_in[6:0];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         word_out <= DOFD_RST_WORD;
         flags_out <= DOFD_RST_FLAGS;
      end else begin
         word_out <= next_word;
         flags_out <= next_flags;
      end
   end

   always_comb begin
      pready_out = 1'b1;
      pslverr_out = psel_in & penable_in & ~rd_hit_in;
      rdata_q_out = (psel_in & ~pwrite_in & rd_hit_in) ? rd_mux_in : 32'h0000_0000;
   end
endmodule

// ### verif/dofd_top_monitor.sv
// Purpose: Port-level checker for the opcode field decoder
// Assumes: Decode outputs settle one edge after a register write lands
// Notes: Bound to dofd_top at the foot of this file
`timescale 1ns/100ps
module dofd_top_monitor
   import dofd_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic [5:0] reg_sel1_out,
   input wire logic [2:0] reg_idx1_out,
   input wire logic [5:0] reg_sel2_out,
   input wire logic [2:0] reg_idx2_out,
   input wire logic cond_true_out,
   input wire logic [15:0] shift_const_out,
   input wire logic illegal_out
);
   logic wr_any;
   logic mapped;
   logic seen;
   logic seen_q;
   logic next_seen;
   logic next_seen_q;
   assign wr_any = psel_in && penable_in && pwrite_in && pready_out;
   assign mapped = (paddr_in[11:5] == 7'h00) && (paddr_in[1:0] == 2'h0);
   // Two stages: decode trails the word write by one edge
   always_comb begin
      next_seen = !srst_in && (seen || (wr_any && paddr_in == DOFD_OFF_WORD));
      next_seen_q = !srst_in && seen;
   end
   always_ff @(posedge sys_clk_in) begin
      seen <= next_seen;
      seen_q <= next_seen_q;
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);
   a_ready_high: assert property (pready_out)
      else $error("pready dropped");
   a_shift_onehot: assert property ($onehot0(shift_const_out))
      else $error("shift constant has several bits set");
   a_shift_zero_ill: assert property (seen_q && shift_const_out == 16'h0000
      |-> illegal_out)
      else $error("zero shift constant not flagged");
   a_sel1_none_ill: assert property (seen_q && reg_sel1_out == DOFD_REG_NONE
      |-> illegal_out)
      else $error("unassigned first select not flagged");
   a_sel2_none_ill: assert property (seen_q && reg_sel2_out == DOFD_REG_NONE
      |-> illegal_out)
      else $error("unassigned second select not flagged");
   a_sel1_range: assert property (reg_sel1_out <= DOFD_REG_ACC_B
      || reg_sel1_out == DOFD_REG_ADDR_PTR || reg_sel1_out == DOFD_REG_OFFSET)
      else $error("first select outside its table");
   a_sel2_range: assert property (reg_sel2_out == DOFD_REG_NONE
      || (reg_sel2_out >= DOFD_REG_MODIFIER && reg_sel2_out <= DOFD_REG_LOOP_CNT))
      else $error("second select outside its table");
   // Decode trails a write or a reset release by one edge, so look one edge back
   a_decode_hold: assert property (!$past(srst_in) && !$past(wr_any) |=> $stable({reg_sel1_out,
      reg_idx1_out, reg_sel2_out, reg_idx2_out, cond_true_out, shift_const_out, illegal_out}))
      else $error("decode changed without a write");
   a_err_unmapped: assert property (psel_in && penable_in |-> pslverr_out == !mapped)
      else $error("error response does not match address map");
endmodule

bind dofd_top dofd_top_monitor dofd_top_monitor_inst (
   .sys_clk_in(sys_clk_in), .srst_in(srst_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .reg_sel1_out(reg_sel1_out),
   .reg_idx1_out(reg_idx1_out), .reg_sel2_out(reg_sel2_out), .reg_idx2_out(reg_idx2_out),
   .cond_true_out(cond_true_out), .shift_const_out(shift_const_out),
   .illegal_out(illegal_out));

// ### verif/dofd_pcu_model.sv
// Purpose: Program control unit model that hands words to the decoder over APB
// Assumes: Caller enters a transfer right after a rising edge
// Notes: Idle address and data are inverted so stale values never pass
`timescale 1ns/100ps
module dofd_pcu_model (
   input wire logic sys_clk_in,
   output logic psel_out,
   output logic penable_out,
   output logic pwrite_out,
   output logic [11:0] paddr_out,
   output logic [31:0] pwdata_out,
   output logic [3:0] pstrb_out,
   input wire logic pready_in,
   input wire logic pslverr_in,
   input wire logic [31:0] prdata_in
);
   initial begin
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 12'hFFF;
      pwdata_out = 32'hFFFF_FFFF;
      pstrb_out = 4'h0;
   end
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q, output logic e);
      @(posedge sys_clk_in);
      psel_out <= 1'b1;
      penable_out <= 1'b0;
      pwrite_out <= wr;
      paddr_out <= a;
      pwdata_out <= d;
      pstrb_out <= s;
      @(posedge sys_clk_in);
      penable_out <= 1'b1;
      do begin
         @(posedge sys_clk_in);
      end while (pready_in !== 1'b1);
      q = prdata_in;
      e = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      paddr_out <= ~a;
      pwdata_out <= ~d;
   endtask
endmodule

// ### verif/tb.sv
// Purpose: Self-checking bench for the opcode field decoder
// Assumes: Decode outputs valid one edge after a write lands
// Notes: Expectations are rebuilt here from the encoding tables
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin failures++; \
   $display("mismatch %s exp %0h got %0h", nm, ex, gt); end end
module tb;
   import dofd_pkg::*;
   logic sys_clk_in, srst_in, psel, penable, pwrite, pready, pslverr, cond_t, ill;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] pstrb;
   logic [5:0] sel1, sel2;
   logic [2:0] idx1, idx2;
   logic [15:0] shc;
   logic e;
   int failures, checks_done, cycles;
   dofd_top dofd_top_inst (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .pstrb_in(pstrb), .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
      .reg_sel1_out(sel1), .reg_idx1_out(idx1), .reg_sel2_out(sel2), .reg_idx2_out(idx2),
      .cond_true_out(cond_t), .shift_const_out(shc), .illegal_out(ill));
   dofd_pcu_model dofd_pcu_model_inst (.sys_clk_in(sys_clk_in), .psel_out(psel),
      .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
      .pstrb_out(pstrb), .pready_in(pready), .pslverr_in(pslverr), .prdata_in(prdata));
   initial begin
      sys_clk_in = 1'b0;
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   task automatic results();
      if (failures == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Generous ceiling; the full sequence needs about 2600 cycles
   always @(posedge sys_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         results();
      end
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      dofd_pcu_model_inst.xfer(1'b1, a, d, 4'hF, q, e);
   endtask
   task automatic rd(input logic [11:0] a);
      dofd_pcu_model_inst.xfer(1'b0, a, 32'h0000_0000, 4'hF, q, e);
   endtask
   function automatic dofd_reg_e s1_exp(input logic [4:0] c);
      if (c[4]) return c[3] ? DOFD_REG_OFFSET : DOFD_REG_ADDR_PTR;
      case (c)
         5'h04: return DOFD_REG_X_LO;
         5'h05: return DOFD_REG_X_HI;
         5'h06: return DOFD_REG_Y_LO;
         5'h07: return DOFD_REG_Y_HI;
         5'h08: return DOFD_REG_ACC_A_LOW;
         5'h09: return DOFD_REG_ACC_B_LOW;
         5'h0A: return DOFD_REG_ACC_A_EXT;
         5'h0B: return DOFD_REG_ACC_B_EXT;
         5'h0C: return DOFD_REG_ACC_A_MID;
         5'h0D: return DOFD_REG_ACC_B_MID;
         5'h0E: return DOFD_REG_ACC_A;
         5'h0F: return DOFD_REG_ACC_B;
         default: return DOFD_REG_NONE;
      endcase
   endfunction
   function automatic dofd_reg_e s2_exp(input logic [4:0] c);
      if (c[4:3] == 2'b00) return DOFD_REG_MODIFIER;
      case (c)
         5'h0A: return DOFD_REG_EXT_PTR;
         5'h10: return DOFD_REG_VEC_BASE;
         5'h11: return DOFD_REG_SIZE_COUNT;
         5'h18: return DOFD_REG_STACK_SIZE;
         5'h19: return DOFD_REG_STATUS;
         5'h1A: return DOFD_REG_OP_MODE;
         5'h1B: return DOFD_REG_STACK_IDX;
         5'h1C: return DOFD_REG_STACK_TOP_HI;
         5'h1D: return DOFD_REG_STACK_TOP_LO;
         5'h1E: return DOFD_REG_LOOP_END;
         5'h1F: return DOFD_REG_LOOP_CNT;
         default: return DOFD_REG_NONE;
      endcase
   endfunction
   function automatic logic cond_exp(input logic [3:0] c, input logic [6:0] f);
      logic z, nv, b;
      z = f[DOFD_FLG_Z];
      nv = f[DOFD_FLG_N] ^ f[DOFD_FLG_V];
      case (c[2:0])
         3'h0: b = !f[DOFD_FLG_C];
         3'h1: b = !nv;
         3'h2: b = !z;
         3'h3: b = !f[DOFD_FLG_N];
         3'h4: b = !(z || (!f[DOFD_FLG_U] && !f[DOFD_FLG_E]));
         3'h5: b = !f[DOFD_FLG_E];
         3'h6: b = !f[DOFD_FLG_L];
         default: b = !(z || nv);
      endcase
      return c[3] ? !b : b;
   endfunction
   initial begin
      logic [4:0] s1, s2;
      logic [3:0] n, c, alu;
      logic [6:0] f;
      logic xi, ei;
      logic [7:0] op;
      dofd_reg_e es1, es2;
      srst_in = 1'b1;
      repeat (6) @(posedge sys_clk_in);
      srst_in <= 1'b0;
      `CHK("ill rst", 1'b0, ill)
      rd(DOFD_OFF_WORD);
      `CHK("word rst", DOFD_RST_WORD, q)
      `CHK("shift rst", 16'h0000, shc)
      rd(DOFD_OFF_FLAGS);
      `CHK("flags rst", DOFD_RST_FLAGS, q[6:0])
      // Byte strobe keeps untouched bytes of the word
      wr(DOFD_OFF_WORD, 32'h1234_5678);
      dofd_pcu_model_inst.xfer(1'b1, DOFD_OFF_WORD, 32'hFFFF_FFFF, 4'h2, q, e);
      rd(12'h020);
      `CHK("unmapped err", 1'b1, e)
      `CHK("unmapped data", 32'h0000_0000, q)
      dofd_pcu_model_inst.xfer(1'b1, 12'h020, 32'h0000_0000, 4'hF, q, e);
      `CHK("unmapped wr err", 1'b1, e)
      rd(DOFD_OFF_WORD);
      `CHK("word strobe", 32'h1234_FF78, q)
      for (int i = 0; i < 128; i++) begin
         s1 = 5'(i);
         s2 = 5'(i * 7);
         n = 4'(i);
         c = 4'(i * 3);
         alu = 4'(i * 5);
         f = 7'(i * 37);
         xi = i[1];
         op = 8'(i * 29);
         es1 = s1_exp(s1);
         es2 = s2_exp(s2);
         ei = es1 == DOFD_REG_NONE || es2 == DOFD_REG_NONE || alu[3:2] == 2'b00 || n == 4'h0;
         wr(DOFD_OFF_WORD, {1'b0, alu, xi, s2, s1, op, n, c});
         wr(DOFD_OFF_FLAGS, {25'h0, f});
         repeat (2) @(posedge sys_clk_in);
         `CHK("sel1", es1, sel1)
         if (s1[4]) `CHK("idx1", s1[2:0], idx1)
         `CHK("sel2", es2, sel2)
         if (es2 == DOFD_REG_MODIFIER) `CHK("idx2", s2[2:0], idx2)
         `CHK("shift", (n == 4'h0) ? 16'h0000 : 16'h8000 >> n, shc)
         `CHK("cond", cond_exp(c, f), cond_t)
         `CHK("illegal", ei, ill)
         rd(DOFD_OFF_REGSEL);
         `CHK("dir", xi, q[2])
         rd(DOFD_OFF_ALU);
         `CHK("alu ill", alu[3:2] == 2'b00, q[4])
         rd(DOFD_OFF_CTRL);
         `CHK("ctrl ill", ei, q[0])
         rd(DOFD_OFF_OPCODE);
         // Packed second-operand codes, two bits per pair select
         `CHK("opc", {op[2:0], op[3], op[6:4], op[0], op[1], op[2], op[3], 1'b0,
            2'(16'h9344 >> 2 * op[6:4]), 1'b0, op[5:4], op[7]}, q[17:0])
      end
      results();
   end
endmodule
